// *** rtl/ucr_addr_decode.sv ***
// Address decoder: address plus divisor enable to read and write selects
module ucr_addr_decode
  import ucr_pkg::*;
(
  ucr_bus_if.dec bus
);

  always_comb begin
    bus.rd_sel = SEL_NONE;
    bus.wr_sel = SEL_NONE;
    case (bus.addr)
      ADDR_DATA: begin
        bus.rd_sel = bus.div_en ? SEL_DIV_LOW : SEL_RX_HOLD;
        bus.wr_sel = bus.div_en ? SEL_DIV_LOW : SEL_TX_HOLD;
      end
      ADDR_IE_DIVH: begin
        bus.rd_sel = bus.div_en ? SEL_DIV_HIGH : SEL_INT_EN;
        bus.wr_sel = bus.div_en ? SEL_DIV_HIGH : SEL_INT_EN;
      end
      ADDR_IS_DIVF: begin
        bus.rd_sel = bus.div_en ? SEL_DIV_FRAC : SEL_INT_STAT;
        bus.wr_sel = bus.div_en ? SEL_DIV_FRAC : SEL_FIFO_CTL;
      end
      ADDR_LINE_CTL: begin
        bus.rd_sel = SEL_LINE_CTL;
        bus.wr_sel = SEL_LINE_CTL;
      end
      ADDR_MODEM_CTL: begin
        bus.rd_sel = SEL_MODEM_CTL;
        bus.wr_sel = SEL_MODEM_CTL;
      end
      ADDR_LINE_STAT: begin
        bus.rd_sel = SEL_LINE_STAT;
      end
      ADDR_MODEM_ST: begin
        bus.rd_sel = SEL_MODEM_ST;
        bus.wr_sel = SEL_RS485;
      end
      ADDR_SCRATCH: begin
        bus.rd_sel = SEL_SCRATCH;
        bus.wr_sel = SEL_SCRATCH;
      end
      ADDR_FEATURE: begin
        bus.rd_sel = SEL_FEATURE;
        bus.wr_sel = SEL_FEATURE;
      end
      ADDR_ENH_FUNC: begin
        bus.rd_sel = SEL_ENH_FUNC;
        bus.wr_sel = SEL_ENH_FUNC;
      end
      ADDR_TX_LEVEL: begin
        bus.rd_sel = SEL_TX_LEVEL;
        bus.wr_sel = SEL_TX_TRIG;
      end
      ADDR_RX_LEVEL: begin
        bus.rd_sel = SEL_RX_LEVEL;
        bus.wr_sel = SEL_RX_TRIG;
      end
      ADDR_STOP1: begin
        bus.rd_sel = SEL_FLAGS;
        bus.wr_sel = SEL_STOP1;
      end
      ADDR_STOP2:   bus.wr_sel = SEL_STOP2;
      ADDR_RESUME1: bus.wr_sel = SEL_RESUME1;
      ADDR_RESUME2: bus.wr_sel = SEL_RESUME2;
      default: begin
        bus.rd_sel = SEL_NONE;
        bus.wr_sel = SEL_NONE;
      end
    endcase
  end

endmodule : ucr_addr_decode

// *** rtl/ucr_bus_if.sv ***
// Internal carrier between the register bank and its decoder and flag keeper
interface ucr_bus_if;
  import ucr_pkg::*;
  logic [3:0] addr;
  logic       div_en;
  ucr_sel_e   rd_sel;
  ucr_sel_e   wr_sel;
  logic [3:0] flag_set;
  logic       flag_clr;
  logic [3:0] flags;

  modport dec (input addr, input div_en, output rd_sel, output wr_sel);
  modport flg (input flag_set, input flag_clr, output flags);
  modport bank (output addr, output div_en, input rd_sel, input wr_sel,
                output flag_set, output flag_clr, input flags);
endinterface : ucr_bus_if

// *** rtl/ucr_channel_regs.sv ***
// Register bank of one UART channel behind the 4-bit host register port
module ucr_channel_regs
  import ucr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Host register port
  input  wire logic       cs_i,
  input  wire logic [3:0] addr_i,
  input  wire logic       rd_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  output logic            rdata_vld_o,
  // Status from the channel core
  input  wire logic [7:0] rx_data_i,
  input  wire logic [7:0] int_status_i,
  input  wire logic [7:0] line_status_i,
  input  wire logic [7:0] modem_status_i,
  input  wire logic [7:0] tx_fifo_level_i,
  input  wire logic [7:0] rx_fifo_level_i,
  input  wire logic [3:0] flow_event_i,
  // Data strobes to the channel core
  output logic      [7:0] tx_data_o,
  output logic            tx_push_o,
  output logic            rx_pop_o,
  output logic            fifo_control_wr_o,
  // Configuration to the channel core
  output logic      [7:0] divisor_low_o,
  output logic      [7:0] divisor_high_o,
  output logic      [3:0] divisor_fraction_o,
  output logic      [7:0] interrupt_enable_o,
  output logic      [7:0] fifo_control_o,
  output logic      [7:0] line_control_o,
  output logic      [7:0] modem_control_o,
  output logic      [3:0] rs485_delay_o,
  output logic            tx_disable_o,
  output logic            rx_disable_o,
  output logic      [7:0] feature_control_o,
  output logic      [7:0] enhanced_function_o,
  output logic      [7:0] tx_fifo_trigger_o,
  output logic      [7:0] rx_fifo_trigger_o,
  output logic      [7:0] stop_char_1_o,
  output logic      [7:0] stop_char_2_o,
  output logic      [7:0] resume_char_1_o,
  output logic      [7:0] resume_char_2_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [3:0] div_frac;
    logic [7:0] int_en;
    logic [7:0] fifo_ctl;
    logic [7:0] line_ctl;
    logic [7:0] modem_ctl;
    logic [3:0] rs485_dly;
    logic       tx_dis;
    logic       rx_dis;
    logic [7:0] scratch;
    logic [7:0] feature;
    logic [7:0] enh_func;
    logic [7:0] tx_trig;
    logic [7:0] rx_trig;
    logic [7:0] stop1;
    logic [7:0] stop2;
    logic [7:0] resume1;
    logic [7:0] resume2;
    logic [7:0] tx_data;
    logic       tx_push;
    logic       rx_pop;
    logic       fifo_wr;
    logic [7:0] rdata;
    logic       rvalid;
  } ucr_bank_s;

  localparam ucr_bank_s BANK_RESET = '{
    div_low:   RST_BYTE,
    div_high:  RST_BYTE,
    div_frac:  RST_BYTE[3:0],
    int_en:    RST_BYTE,
    fifo_ctl:  RST_BYTE,
    line_ctl:  RST_BYTE,
    modem_ctl: RST_BYTE,
    rs485_dly: RST_BYTE[3:0],
    tx_dis:    1'b0,
    rx_dis:    1'b0,
    scratch:   RST_BYTE,
    feature:   RST_BYTE,
    enh_func:  RST_BYTE,
    tx_trig:   RST_BYTE,
    rx_trig:   RST_BYTE,
    stop1:     RST_BYTE,
    stop2:     RST_BYTE,
    resume1:   RST_BYTE,
    resume2:   RST_BYTE,
    tx_data:   RST_BYTE,
    tx_push:   1'b0,
    rx_pop:    1'b0,
    fifo_wr:   1'b0,
    rdata:     RST_BYTE,
    rvalid:    1'b0
  };

  ucr_bank_s state_ff;
  ucr_bank_s nxt_state;

  logic       rd_hit;
  logic       wr_hit;
  logic       gate_on;
  logic       wr_gate;
  logic [7:0] rd_val;

  ucr_bus_if bus ();

  // ****************************************
  // Decoder and flag keeper
  // ****************************************
  assign bus.addr     = addr_i;
  assign bus.div_en   = state_ff.line_ctl[DIV_EN_BIT];
  assign bus.flag_set = flow_event_i;
  assign bus.flag_clr = rd_hit && (bus.rd_sel == SEL_FLAGS);

  ucr_addr_decode u_decode (
    .bus (bus.dec)
  );

  ucr_flow_flags u_flags (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus   (bus.flg)
  );

  assign rd_hit  = cs_i && rd_i;
  assign wr_hit  = cs_i && wr_i;
  assign gate_on = state_ff.enh_func[GATE_BIT];
  // Stored gate decides; a write to the gate acts from the next access
  assign wr_gate = gate_on;

  // ****************************************
  // Read multiplexer
  // ****************************************
  always_comb begin
    rd_val = RESERVED_READ;
    case (bus.rd_sel)
      SEL_RX_HOLD:   rd_val = rx_data_i;
      SEL_DIV_LOW:   rd_val = state_ff.div_low;
      SEL_DIV_HIGH:  rd_val = state_ff.div_high;
      SEL_DIV_FRAC:  rd_val = {4'h0, state_ff.div_frac};
      SEL_INT_EN:    rd_val = state_ff.int_en;
      SEL_INT_STAT:  rd_val = ucr_gate(int_status_i, IS_GATED, gate_on);
      SEL_LINE_CTL:  rd_val = state_ff.line_ctl;
      SEL_MODEM_CTL: rd_val = state_ff.modem_ctl;
      SEL_LINE_STAT: rd_val = line_status_i;
      SEL_MODEM_ST:  rd_val = modem_status_i;
      SEL_SCRATCH:   rd_val = state_ff.scratch;
      SEL_FEATURE:   rd_val = state_ff.feature;
      SEL_ENH_FUNC:  rd_val = state_ff.enh_func;
      SEL_TX_LEVEL:  rd_val = tx_fifo_level_i;
      SEL_RX_LEVEL:  rd_val = rx_fifo_level_i;
      SEL_FLAGS:     rd_val = {4'h0, bus.flags};
      default:       rd_val = RESERVED_READ;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_state         = state_ff;
    nxt_state.tx_push = 1'b0;
    nxt_state.fifo_wr = 1'b0;
    nxt_state.rx_pop  = rd_hit && (bus.rd_sel == SEL_RX_HOLD);
    nxt_state.rvalid  = rd_hit;
    if (rd_hit) begin
      nxt_state.rdata = rd_val;
    end
    if (wr_hit) begin
      case (bus.wr_sel)
        SEL_TX_HOLD: begin
          nxt_state.tx_data = wdata_i;
          nxt_state.tx_push = 1'b1;
        end
        SEL_DIV_LOW:   nxt_state.div_low  = wdata_i;
        SEL_DIV_HIGH:  nxt_state.div_high = wdata_i;
        SEL_DIV_FRAC:  nxt_state.div_frac = wdata_i[3:0] & FRACTION_MASK[3:0];
        SEL_INT_EN: begin
          nxt_state.int_en = ucr_gate(wdata_i & IE_WRITE_MASK, IE_GATED, wr_gate);
        end
        SEL_FIFO_CTL: begin
          nxt_state.fifo_ctl = ucr_gate(wdata_i, FC_GATED, wr_gate);
          nxt_state.fifo_wr  = 1'b1;
        end
        SEL_LINE_CTL:  nxt_state.line_ctl = wdata_i;
        SEL_MODEM_CTL: begin
          nxt_state.modem_ctl = ucr_gate(wdata_i, MC_GATED, wr_gate);
        end
        SEL_RS485: begin
          // Whole write byte is enhanced; ignored while the gate is off
          if (wr_gate) begin
            nxt_state.rs485_dly = wdata_i[DLY_MSB:DLY_LSB];
            nxt_state.tx_dis    = wdata_i[TX_DIS_BIT];
            nxt_state.rx_dis    = wdata_i[RX_DIS_BIT];
          end
        end
        SEL_SCRATCH:  nxt_state.scratch  = wdata_i;
        SEL_FEATURE:  nxt_state.feature  = wdata_i;
        SEL_ENH_FUNC: nxt_state.enh_func = wdata_i;
        SEL_TX_TRIG:  nxt_state.tx_trig  = wdata_i;
        SEL_RX_TRIG:  nxt_state.rx_trig  = wdata_i;
        SEL_STOP1:    nxt_state.stop1    = wdata_i;
        SEL_STOP2:    nxt_state.stop2    = wdata_i;
        SEL_RESUME1:  nxt_state.resume1  = wdata_i;
        SEL_RESUME2:  nxt_state.resume2  = wdata_i;
        default:      nxt_state.scratch  = state_ff.scratch;
      endcase
    end
    // Dropping the gate clears every gated field so none stays in force
    if (!nxt_state.enh_func[GATE_BIT]) begin
      nxt_state.int_en    = ucr_gate(nxt_state.int_en, IE_GATED, 1'b0);
      nxt_state.fifo_ctl  = ucr_gate(nxt_state.fifo_ctl, FC_GATED, 1'b0);
      nxt_state.modem_ctl = ucr_gate(nxt_state.modem_ctl, MC_GATED, 1'b0);
      nxt_state.rs485_dly = 4'h0;
      nxt_state.tx_dis    = 1'b0;
      nxt_state.rx_dis    = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= BANK_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rdata_o             = state_ff.rdata;
  assign rdata_vld_o         = state_ff.rvalid;
  assign tx_data_o           = state_ff.tx_data;
  assign tx_push_o           = state_ff.tx_push;
  assign rx_pop_o            = state_ff.rx_pop;
  assign fifo_control_wr_o   = state_ff.fifo_wr;
  assign divisor_low_o       = state_ff.div_low;
  assign divisor_high_o      = state_ff.div_high;
  assign divisor_fraction_o  = state_ff.div_frac;
  assign interrupt_enable_o  = state_ff.int_en;
  assign fifo_control_o      = state_ff.fifo_ctl;
  assign line_control_o      = state_ff.line_ctl;
  assign modem_control_o     = state_ff.modem_ctl;
  assign rs485_delay_o       = state_ff.rs485_dly;
  assign tx_disable_o        = state_ff.tx_dis;
  assign rx_disable_o        = state_ff.rx_dis;
  assign feature_control_o   = state_ff.feature;
  assign enhanced_function_o = state_ff.enh_func;
  assign tx_fifo_trigger_o   = state_ff.tx_trig;
  assign rx_fifo_trigger_o   = state_ff.rx_trig;
  assign stop_char_1_o       = state_ff.stop1;
  assign stop_char_2_o       = state_ff.stop2;
  assign resume_char_1_o     = state_ff.resume1;
  assign resume_char_2_o     = state_ff.resume2;

endmodule : ucr_channel_regs

// *** rtl/ucr_flow_flags.sv ***
// Sticky flow-control character flags, cleared by a host read
module ucr_flow_flags
  import ucr_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  ucr_bus_if.flg     bus
);

  typedef struct packed {
    logic [3:0] flags;
  } ucr_flg_s;

  ucr_flg_s state_ff;
  ucr_flg_s nxt_state;

  // A flag raised in the clearing cycle survives the read
  always_comb begin
    nxt_state       = state_ff;
    nxt_state.flags = (bus.flag_clr ? RST_FLAGS : state_ff.flags) | bus.flag_set;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= '{flags: RST_FLAGS};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign bus.flags = state_ff.flags;

endmodule : ucr_flow_flags

// *** rtl/ucr_pkg.sv ***
// Constants, types and helpers for the per-channel register bank
// Summary of operation
// - Each channel has sixteen byte registers chosen by a four-bit address.
// - Addresses 0-7 hold the standard set, 8-15 the enhanced registers.
// - Divisor enable clear: address 0 reads receive byte, writes transmit byte.
// - Divisor enable set: addresses 0-2 reach divisor low, high, 4-bit fraction.
// - Divisor enable clear: address 1 is the interrupt enable register.
// - Divisor enable clear: address 2 reads interrupt status, writes FIFO control.
// - Address 3 is always line control; its bit 7 is divisor enable.
// - Address 4 is always modem control, read and write.
// - Address 5 reads the eight line status flags.
// - Address 6 reads modem status; writes set RS-485 delay and disables.
// - Address 7 is a scratch byte read back unchanged.
// - Address 9 is enhanced function; bit 4 gates enhanced fields.
// - Address 10 reads transmit FIFO level, writes transmit trigger level.
// - Address 11 reads receive FIFO level, writes receive trigger level.
// - Address 12 writes stop character 1, reads flow-control flags.
// - Addresses 13-15 write stop 2 and resume 1, 2; reads reserved.
// - Enhanced fields act only while the gate bit is set.
package ucr_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] ADDR_DATA      = 4'h0;
  localparam logic [3:0] ADDR_IE_DIVH   = 4'h1;
  localparam logic [3:0] ADDR_IS_DIVF   = 4'h2;
  localparam logic [3:0] ADDR_LINE_CTL  = 4'h3;
  localparam logic [3:0] ADDR_MODEM_CTL = 4'h4;
  localparam logic [3:0] ADDR_LINE_STAT = 4'h5;
  localparam logic [3:0] ADDR_MODEM_ST  = 4'h6;
  localparam logic [3:0] ADDR_SCRATCH   = 4'h7;
  localparam logic [3:0] ADDR_FEATURE   = 4'h8;
  localparam logic [3:0] ADDR_ENH_FUNC  = 4'h9;
  localparam logic [3:0] ADDR_TX_LEVEL  = 4'hA;
  localparam logic [3:0] ADDR_RX_LEVEL  = 4'hB;
  localparam logic [3:0] ADDR_STOP1     = 4'hC;
  localparam logic [3:0] ADDR_STOP2     = 4'hD;
  localparam logic [3:0] ADDR_RESUME1   = 4'hE;
  localparam logic [3:0] ADDR_RESUME2   = 4'hF;

  // ****************************************
  // Field positions and masks
  // ****************************************
  localparam int         DIV_EN_BIT     = 7;
  localparam int         GATE_BIT       = 4;
  localparam logic [7:0] FRACTION_MASK  = 8'h0F;
  localparam logic [7:0] IE_WRITE_MASK  = 8'hEF;
  localparam logic [7:0] IE_GATED       = 8'hE0;
  localparam logic [7:0] IS_GATED       = 8'h30;
  localparam logic [7:0] FC_GATED       = 8'h30;
  localparam logic [7:0] MC_GATED       = 8'hEC;
  localparam logic [7:0] MS_WRITE_MASK  = 8'hFC;
  localparam int         DLY_MSB        = 7;
  localparam int         DLY_LSB        = 4;
  localparam int         TX_DIS_BIT     = 3;
  localparam int         RX_DIS_BIT     = 2;
  localparam logic [7:0] RESERVED_READ  = 8'h00;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [3:0] RST_FLAGS      = 4'h0;

  typedef enum logic [4:0] {
    SEL_NONE      = 5'b00000,
    SEL_RX_HOLD   = 5'b00001,
    SEL_TX_HOLD   = 5'b00010,
    SEL_DIV_LOW   = 5'b00011,
    SEL_DIV_HIGH  = 5'b00100,
    SEL_DIV_FRAC  = 5'b00101,
    SEL_INT_EN    = 5'b00110,
    SEL_INT_STAT  = 5'b00111,
    SEL_FIFO_CTL  = 5'b01000,
    SEL_LINE_CTL  = 5'b01001,
    SEL_MODEM_CTL = 5'b01010,
    SEL_LINE_STAT = 5'b01011,
    SEL_MODEM_ST  = 5'b01100,
    SEL_RS485     = 5'b01101,
    SEL_SCRATCH   = 5'b01110,
    SEL_FEATURE   = 5'b01111,
    SEL_ENH_FUNC  = 5'b10000,
    SEL_TX_LEVEL  = 5'b10001,
    SEL_TX_TRIG   = 5'b10010,
    SEL_RX_LEVEL  = 5'b10011,
    SEL_RX_TRIG   = 5'b10100,
    SEL_FLAGS     = 5'b10101,
    SEL_STOP1     = 5'b10110,
    SEL_STOP2     = 5'b10111,
    SEL_RESUME1   = 5'b11000,
    SEL_RESUME2   = 5'b11001
  } ucr_sel_e;

  // Clears the gated bits of a byte while the enhanced gate is off
  function automatic logic [7:0] ucr_gate(input logic [7:0] val,
                                          input logic [7:0] mask,
                                          input logic       en);
    ucr_gate = en ? val : (val & ~mask);
  endfunction : ucr_gate

endpackage : ucr_pkg

// *** sim/uart_channel_register_decode_test.sv ***
// Self-checking bench for the channel register bank
module uart_channel_register_decode_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ucr_pkg::*;
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
  int cmp_count = 0;
  int mismatches = 0;
  logic clk_i = 0, rst_i = 1, cs_i = 0, rd_i = 0, wr_i = 0;
  logic [3:0] addr_i = 4'h0, ev_req = 4'h0, flow_event_i, divisor_fraction_o, rs485_delay_o;
  logic [7:0] wdata_i = 8'h00, rdata_o, rx_data_i, int_status_i, line_status_i, modem_status_i;
  logic [7:0] tx_fifo_level_i, rx_fifo_level_i, tx_data_o, divisor_low_o, divisor_high_o;
  logic [7:0] interrupt_enable_o, fifo_control_o, line_control_o, modem_control_o;
  logic [7:0] feature_control_o, enhanced_function_o, tx_fifo_trigger_o, rx_fifo_trigger_o;
  logic [7:0] stop_char_1_o, stop_char_2_o, resume_char_1_o, resume_char_2_o, d;
  logic rdata_vld_o, tx_push_o, rx_pop_o, fifo_control_wr_o, tx_disable_o, rx_disable_o;

  always #5 clk_i = ~clk_i;

  ucr_core_model i_core (.clk_i, .ev_req_i(ev_req), .rx_data_o(rx_data_i),
    .int_status_o(int_status_i), .line_status_o(line_status_i), .modem_status_o(modem_status_i),
    .tx_level_o(tx_fifo_level_i), .rx_level_o(rx_fifo_level_i), .flow_event_o(flow_event_i));
  ucr_channel_regs i_dut (.clk_i, .rst_i, .cs_i, .addr_i, .rd_i, .wr_i, .wdata_i, .rdata_o,
    .rdata_vld_o, .rx_data_i, .int_status_i, .line_status_i, .modem_status_i, .tx_fifo_level_i,
    .rx_fifo_level_i, .flow_event_i, .tx_data_o, .tx_push_o, .rx_pop_o, .fifo_control_wr_o,
    .divisor_low_o, .divisor_high_o, .divisor_fraction_o, .interrupt_enable_o, .fifo_control_o,
    .line_control_o, .modem_control_o, .rs485_delay_o, .tx_disable_o, .rx_disable_o,
    .feature_control_o, .enhanced_function_o, .tx_fifo_trigger_o, .rx_fifo_trigger_o,
    .stop_char_1_o, .stop_char_2_o, .resume_char_1_o, .resume_char_2_o);

  // ****************************************
  // Host bus cycles
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    cs_i <= 1'b1; wr_i <= 1'b1; addr_i <= a; wdata_i <= v;
    @(posedge clk_i);
    cs_i <= 1'b0; wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    cs_i <= 1'b1; rd_i <= 1'b1; addr_i <= a;
    @(posedge clk_i);
    cs_i <= 1'b0; rd_i <= 1'b0;
    #1;
    d = rdata_o;
    `CHK("read valid", 1'b1, rdata_vld_o)
  endtask : rd

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_divisor();
    wr(4'h3, 8'h83);
    wr(4'h0, 8'h5A); `CHK("no push", 1'b0, tx_push_o)
    wr(4'h1, 8'hA5); wr(4'h2, 8'hFF);
    `CHK("div low out", 8'h5A, divisor_low_o)
    `CHK("div high out", 8'hA5, divisor_high_o)
    rd(4'h0); `CHK("div low", 8'h5A, d)
    rd(4'h1); `CHK("div high", 8'hA5, d)
    rd(4'h2); `CHK("div frac", 8'h0F, d)
    `CHK("frac out", 4'hF, divisor_fraction_o)
    rd(4'h3); `CHK("line ctl", 8'h83, d)
    wr(4'h3, 8'h03);
    `CHK("line ctl out", 8'h03, line_control_o)
    $display("test divisor done");
  endtask : t_divisor

  task automatic t_standard();
    wr(4'h0, 8'h3C); `CHK("tx byte", 8'h3C, tx_data_o)
    `CHK("tx push", 1'b1, tx_push_o)
    rd(4'h0); `CHK("rx byte", 8'hC3, d)
    `CHK("rx pop", 1'b1, rx_pop_o)
    `CHK("push ends", 1'b0, tx_push_o)
    wr(4'h1, 8'hFF); rd(4'h1); `CHK("int en std", 8'h0F, d)
    wr(4'h2, 8'hFF); `CHK("fifo ctl", 8'hCF, fifo_control_o)
    `CHK("fifo ctl wr", 1'b1, fifo_control_wr_o)
    rd(4'h2); `CHK("int stat", 8'hCF, d)
    wr(4'h4, 8'hFF); rd(4'h4); `CHK("modem ctl std", 8'h13, d)
    wr(4'h5, 8'h00); rd(4'h5); `CHK("line stat", 8'h61, d)
    wr(4'h6, 8'hFC); `CHK("rs485 ignored", 4'h0, rs485_delay_o)
    rd(4'h6); `CHK("modem stat", 8'hB4, d)
    wr(4'h7, 8'h96); rd(4'h7); `CHK("scratch", 8'h96, d)
    $display("test standard done");
  endtask : t_standard

  task automatic t_enhanced();
    wr(4'h9, 8'h1A); rd(4'h9); `CHK("enh func", 8'h1A, d)
    `CHK("enh func out", 8'h1A, enhanced_function_o)
    wr(4'h1, 8'hFF); `CHK("int en enh", 8'hEF, interrupt_enable_o)
    wr(4'h4, 8'hFF); `CHK("modem ctl enh", 8'hFF, modem_control_o)
    wr(4'h2, 8'h30); `CHK("fifo ctl enh", 8'h30, fifo_control_o)
    wr(4'h6, 8'hA8); `CHK("rs485 delay", 4'hA, rs485_delay_o)
    `CHK("tx dis", 1'b1, tx_disable_o)
    `CHK("rx dis", 1'b0, rx_disable_o)
    rd(4'h2); `CHK("int stat enh", 8'hFF, d)
    wr(4'h9, 8'h0A); rd(4'h1); `CHK("int en cleared", 8'h0F, d)
    `CHK("modem ctl cleared", 8'h13, modem_control_o)
    $display("test enhanced done");
  endtask : t_enhanced

  task automatic t_upper();
    wr(4'h8, 8'h5C); rd(4'h8); `CHK("feature", 8'h5C, d)
    `CHK("feature out", 8'h5C, feature_control_o)
    wr(4'hA, 8'h21); `CHK("tx trig", 8'h21, tx_fifo_trigger_o)
    rd(4'hA); `CHK("tx level", 8'h12, d)
    wr(4'hB, 8'h43); `CHK("rx trig", 8'h43, rx_fifo_trigger_o)
    rd(4'hB); `CHK("rx level", 8'h34, d)
    wr(4'hC, 8'h13); wr(4'hD, 8'h93); wr(4'hE, 8'h11); wr(4'hF, 8'h91);
    `CHK("stop 1", 8'h13, stop_char_1_o)
    `CHK("stop 2", 8'h93, stop_char_2_o)
    `CHK("resume 1", 8'h11, resume_char_1_o)
    `CHK("resume 2", 8'h91, resume_char_2_o)
    for (int a = 13; a < 16; a++) begin
      rd(a[3:0]); `CHK("reserved", 8'h00, d)
    end
    $display("test upper done");
  endtask : t_upper

  task automatic t_flags();
    @(posedge clk_i); ev_req <= 4'h5;
    @(posedge clk_i); ev_req <= 4'h0;
    rd(4'hC); `CHK("flags", 8'h05, d)
    rd(4'hC); `CHK("flags cleared", 8'h00, d)
    // Event lands in the very cycle of the clearing read
    @(posedge clk_i); ev_req <= 4'h2;
    fork
      rd(4'hC);
      begin
        @(posedge clk_i); ev_req <= 4'h0;
      end
    join
    `CHK("flags old", 8'h00, d)
    rd(4'hC); `CHK("set wins", 8'h02, d)
    $display("test flags done");
  endtask : t_flags

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_divisor();
    t_standard();
    t_enhanced();
    t_upper();
    t_flags();
    print_verdict();
  end

  // Whole run is some 110 cycles; this leaves ample margin
  initial begin
    #50000;
    mismatches++;
    print_verdict();
  end
endmodule : uart_channel_register_decode_test

// *** sim/ucr_channel_regs_properties.sv ***
// Port-level checker for the channel register bank
module ucr_channel_regs_properties
  import ucr_pkg::*;
(
  // Clock, reset and host port
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cs_i,
  input wire logic [3:0] addr_i,
  input wire logic       rd_i,
  input wire logic       wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic       rdata_vld_o,
  // Core side
  input wire logic [7:0] rx_data_i,
  input wire logic [7:0] int_status_i,
  input wire logic [7:0] line_status_i,
  input wire logic [7:0] tx_data_o,
  input wire logic       tx_push_o,
  input wire logic       rx_pop_o,
  input wire logic       fifo_control_wr_o,
  input wire logic [7:0] interrupt_enable_o,
  input wire logic [7:0] fifo_control_o,
  input wire logic [7:0] line_control_o,
  input wire logic [7:0] modem_control_o,
  input wire logic [3:0] rs485_delay_o,
  input wire logic       tx_disable_o,
  input wire logic       rx_disable_o,
  input wire logic [7:0] enhanced_function_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rd_go;
  logic wr_go;
  logic dv;
  assign rd_go = cs_i && rd_i;
  assign wr_go = cs_i && wr_i;
  assign dv    = line_control_o[7];

  read_valid_a: assert property (rd_go |=> rdata_vld_o)
    else $error("read answer missing");
  line_stat_a: assert property (rd_go && addr_i == 4'h5 |=> rdata_o == $past(line_status_i))
    else $error("line status read wrong");
  tx_push_a: assert property (wr_go && addr_i == 4'h0 && !dv |=>
    tx_push_o && tx_data_o == $past(wdata_i))
    else $error("transmit byte not pushed");
  rx_pop_a: assert property (rd_go && addr_i == 4'h0 && !dv |=>
    rx_pop_o && rdata_o == $past(rx_data_i))
    else $error("receive byte not popped");
  frac_read_a: assert property (rd_go && addr_i == 4'h2 && dv |=> rdata_o[7:4] == 4'h0)
    else $error("fraction upper bits set");
  rsvd_read_a: assert property (rd_go && addr_i >= 4'hD |=> rdata_o == 8'h00)
    else $error("reserved read not zero");
  line_ctl_a: assert property (wr_go && addr_i == 4'h3 |=> line_control_o == $past(wdata_i))
    else $error("line control not stored");
  fifo_wr_a: assert property (wr_go && addr_i == 4'h2 && !dv |=> fifo_control_wr_o)
    else $error("fifo control strobe missing");
  isr_gate_a: assert property (rd_go && addr_i == 4'h2 && !dv && !enhanced_function_o[4]
    |=> rdata_o == ($past(int_status_i) & ~IS_GATED))
    else $error("gated status bits leaked");
  gated_zero_a: assert property (!enhanced_function_o[4] |-> (interrupt_enable_o & IE_GATED) == 0
    && (fifo_control_o & FC_GATED) == 0 && (modem_control_o & MC_GATED) == 0
    && rs485_delay_o == 0 && !tx_disable_o && !rx_disable_o)
    else $error("gated field set with gate off");
  ie_bit4_a: assert property (interrupt_enable_o[4] == 1'b0)
    else $error("interrupt enable bit 4 set");
endmodule : ucr_channel_regs_properties

bind ucr_channel_regs ucr_channel_regs_properties i_props (.clk_i, .rst_i, .cs_i, .addr_i, .rd_i,
  .wr_i, .wdata_i, .rdata_o, .rdata_vld_o, .rx_data_i, .int_status_i, .line_status_i, .tx_data_o,
  .tx_push_o, .rx_pop_o, .fifo_control_wr_o, .interrupt_enable_o, .fifo_control_o,
  .line_control_o, .modem_control_o, .rs485_delay_o, .tx_disable_o, .rx_disable_o,
  .enhanced_function_o);

// *** sim/ucr_core_model.sv ***
// Behavioural channel core that feeds status into the register bank
module ucr_core_model #(
  parameter logic [7:0] RXB = 8'hC3,
  parameter logic [7:0] ISB = 8'hFF,
  parameter logic [7:0] LSB = 8'h61,
  parameter logic [7:0] MSB = 8'hB4,
  parameter logic [7:0] TXL = 8'h12,
  parameter logic [7:0] RXL = 8'h34
) (
  // Clock and event request
  input  wire logic       clk_i,
  input  wire logic [3:0] ev_req_i,
  // Status towards the bank
  output logic      [7:0] rx_data_o,
  output logic      [7:0] int_status_o,
  output logic      [7:0] line_status_o,
  output logic      [7:0] modem_status_o,
  output logic      [7:0] tx_level_o,
  output logic      [7:0] rx_level_o,
  output logic      [3:0] flow_event_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign rx_data_o      = RXB;
  assign int_status_o   = ISB;
  assign line_status_o  = LSB;
  assign modem_status_o = MSB;
  assign tx_level_o     = TXL;
  assign rx_level_o     = RXL;
  // One-cycle pulses, as a real detector gives
  initial flow_event_o = 4'h0;
  always @(posedge clk_i) begin
    flow_event_o <= ev_req_i;
  end
endmodule : ucr_core_model
